/* File: core/pin_port_defines.svh */
// Constants for the shared pin port: register map, reset values, sizes.
// Assumes a 32-bit APB slave with 12-bit byte addresses.
`ifndef PIN_PORT_DEFINES_SVH
`define PIN_PORT_DEFINES_SVH

// ****************************************************************
// Sizes
// ****************************************************************
`define PP_NPINS       16
`define PP_NRP         8
`define PP_NRI         4
`define PP_NRO         4
`define PP_SELW        6
`define PP_ADDRW       12
`define PP_IMPL_MASK   16'h7FFF

// ****************************************************************
// Register offsets (byte addresses)
// ****************************************************************
`define PP_DIR_OFF     12'h000
`define PP_LAT_OFF     12'h004
`define PP_PORT_OFF    12'h008
`define PP_ANSEL_OFF   12'h00C
`define PP_INSEL_BASE  12'h010
`define PP_OUTSEL_BASE 12'h030

// ****************************************************************
// Reset values
// ****************************************************************
`define PP_DIR_RST     16'hFFFF
`define PP_LAT_RST     16'h0000
`define PP_ANSEL_RST   16'h0000
`define PP_INSEL_RST   6'h3F
`define PP_OUTSEL_RST  6'h00

`endif

/* File: core/pin_port_pkg.sv */
// Types shared by the shared pin port files.
// Relies on pin_port_defines.svh for all sizes.
`include "pin_port_defines.svh"

package pin_port_pkg;

    typedef logic [`PP_NPINS-1:0] port_t;
    typedef logic [`PP_SELW-1:0]  sel_t;

    typedef struct packed {
        port_t                dir;
        port_t                lat;
        port_t                ansel;
        sel_t [`PP_NRI-1:0]   insel;
        sel_t [`PP_NRP-1:0]   outsel;
    } port_state_s;

endpackage

/* File: core/pin_sync.sv */
// Two-flop synchroniser for a vector of pad levels.
// Assumes the pads are asynchronous to pclk; clk_en freezes both stages.
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
    parameter int W = 1
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic         clk_en,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } sync_s;

    sync_s st_reg;
    sync_s st_next;

    always_comb begin
        st_next = st_reg;
        if (clk_en) begin
            st_next.s1 = d;
            st_next.s2 = st_reg.s1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign q = st_reg.s2;

endmodule

`default_nettype wire

/* File: core/pin_cell.sv */
// Output ownership for one pin: fixed, remapped, parallel port, port bit.
// Assumes each *_act input already means "enabled and driving".
`timescale 1ns/1ps
`default_nettype none

module pin_cell (
    input  wire logic impl,
    input  wire logic dir,
    input  wire logic lat,
    input  wire logic fix_act,
    input  wire logic fix_do,
    input  wire logic rp_act,
    input  wire logic rp_do,
    input  wire logic pmp_act,
    input  wire logic pmp_do,
    output logic      pad_o,
    output logic      pad_oe,
    output logic      port_drv
);

    always_comb begin
        pad_o    = 1'b0;
        pad_oe   = 1'b0;
        port_drv = 1'b0;
        // Pair of muxes picks data and enable together
        if (fix_act) begin
            pad_o  = fix_do;
            pad_oe = 1'b1;
        end else if (rp_act) begin
            pad_o  = rp_do;
            pad_oe = 1'b1;
        end else if (pmp_act) begin
            pad_o  = pmp_do;
            pad_oe = 1'b1;
        end else if (impl && !dir) begin
            pad_o    = lat;
            pad_oe   = 1'b1;
            port_drv = 1'b1;
        end
    end

endmodule

`default_nettype wire

/* File: core/pin_port.sv */
// Shared pin port with remappable pin matrix, APB register slave.
// Assumes pads are asynchronous, peripherals run on pclk.
//
// The implementer's own choices: the APB register port and the address map.
`timescale 1ns/1ps
`default_nettype none

`include "pin_port_defines.svh"

module pin_port (
    input  wire logic                     pclk,
    input  wire logic                     presetn,
    input  wire logic                     clk_en,
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [`PP_ADDRW-1:0]     paddr,
    input  wire logic [31:0]              pwdata,
    output logic      [31:0]              prdata,
    output logic                          pready,
    output logic                          pslverr,
    input  wire logic [`PP_NPINS-1:0]     pad_in,
    output logic      [`PP_NPINS-1:0]     pad_out,
    output logic      [`PP_NPINS-1:0]     pad_oe,
    input  wire logic [`PP_NPINS-1:0]     fixed_en,
    input  wire logic [`PP_NPINS-1:0]     fixed_oe,
    input  wire logic [`PP_NPINS-1:0]     fixed_do,
    output logic      [`PP_NPINS-1:0]     fixed_in,
    input  wire logic [`PP_NPINS-1:0]     parallel_master_port_en,
    input  wire logic [`PP_NPINS-1:0]     parallel_master_port_oe,
    input  wire logic [`PP_NPINS-1:0]     parallel_master_port_do,
    input  wire logic [`PP_NRO-1:0]       rp_out_oe,
    input  wire logic [`PP_NRO-1:0]       rp_out_data,
    output logic      [`PP_NRI-1:0]       rp_in_data
);

    // ****************************************************************
    // State
    // ****************************************************************
    pin_port_pkg::port_state_s st_reg;
    pin_port_pkg::port_state_s st_next;

    pin_port_pkg::port_t pin_sync_q;
    pin_port_pkg::port_t fix_act;
    pin_port_pkg::port_t rp_act;
    pin_port_pkg::port_t rp_do;
    pin_port_pkg::port_t pmp_act;
    pin_port_pkg::port_t port_drv;
    pin_port_pkg::port_t pin_clean;
    pin_port_pkg::port_t impl;
    pin_port_pkg::port_t dir_rd;
    pin_port_pkg::port_t lat_rd;

    logic        acc;
    logic        wr;
    logic        hit;
    logic [31:0] rd_mux;

    assign impl   = `PP_IMPL_MASK;
    assign dir_rd = st_reg.dir & impl;
    assign lat_rd = st_reg.lat & impl;

    // ****************************************************************
    // Pad input synchroniser
    // ****************************************************************
    pin_sync #(
        .W (`PP_NPINS)
    ) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .clk_en  (clk_en),
        .d       (pad_in),
        .q       (pin_sync_q)
    );

    // Pin level with own port drive masked off, so no loop-through
    assign pin_clean = pin_sync_q & ~port_drv & impl;
    // Fixed inputs, including input-only ones, just see the pin
    assign fixed_in  = pin_clean & fixed_en;

    // ****************************************************************
    // Output ownership per pin
    // ****************************************************************
    assign fix_act = fixed_en & fixed_oe & impl;
    assign pmp_act = parallel_master_port_en & parallel_master_port_oe & impl;

    genvar gi;
    generate
        for (gi = 0; gi < `PP_NPINS; gi++) begin : g_pin
            if (gi < `PP_NRP) begin : g_rp
                pin_port_pkg::sel_t      osel;
                logic [`PP_SELW-1:0]     oidx;
                logic                    routed;
                assign osel   = st_reg.outsel[gi];
                assign oidx   = osel - `PP_SELW'(1);
                // Zero or unknown code leaves the pin disconnected
                assign routed = (osel != '0) && (osel <= `PP_SELW'(`PP_NRO));
                assign rp_act[gi] = routed && impl[gi] && rp_out_oe[oidx[1:0]];
                assign rp_do[gi]  = routed && rp_out_data[oidx[1:0]];
            end else begin : g_fix
                assign rp_act[gi] = 1'b0;
                assign rp_do[gi]  = 1'b0;
            end
            pin_cell u_cell (
                .impl     (impl[gi]),
                .dir      (st_reg.dir[gi]),
                .lat      (st_reg.lat[gi]),
                .fix_act  (fix_act[gi]),
                .fix_do   (fixed_do[gi]),
                .rp_act   (rp_act[gi]),
                .rp_do    (rp_do[gi]),
                .pmp_act  (pmp_act[gi]),
                .pmp_do   (parallel_master_port_do[gi]),
                .pad_o    (pad_out[gi]),
                .pad_oe   (pad_oe[gi]),
                .port_drv (port_drv[gi])
            );
        end
    endgenerate

    // ****************************************************************
    // Remapped inputs
    // ****************************************************************
    // Only feeds data inward; never touches pad_oe
    genvar gj;
    generate
        for (gj = 0; gj < `PP_NRI; gj++) begin : g_rin
            pin_port_pkg::sel_t isel;
            logic               ivalid;
            assign isel   = st_reg.insel[gj];
            assign ivalid = isel < `PP_SELW'(`PP_NRP);
            assign rp_in_data[gj] = ivalid
                && !st_reg.ansel[isel[2:0]]
                && pin_clean[isel[2:0]];
        end
    endgenerate

    // ****************************************************************
    // APB slave
    // ****************************************************************
    // Zero wait states; a frozen clock stretches the access instead
    assign pready  = clk_en;
    assign acc     = psel && penable;
    assign wr      = acc && pwrite && clk_en;
    assign pslverr = acc && !hit;
    assign prdata  = (acc && !pwrite) ? rd_mux : 32'h0000_0000;

    always_comb begin
        st_next = st_reg;
        hit     = 1'b1;
        rd_mux  = 32'h0000_0000;
        case (paddr)
            `PP_DIR_OFF: begin
                rd_mux[`PP_NPINS-1:0] = dir_rd;
                if (wr) begin
                    st_next.dir = pwdata[`PP_NPINS-1:0];
                end
            end
            `PP_LAT_OFF: begin
                rd_mux[`PP_NPINS-1:0] = lat_rd;
                if (wr) begin
                    st_next.lat = pwdata[`PP_NPINS-1:0];
                end
            end
            `PP_PORT_OFF: begin
                rd_mux[`PP_NPINS-1:0] = pin_sync_q & impl;
                if (wr) begin
                    st_next.lat = pwdata[`PP_NPINS-1:0];
                end
            end
            `PP_ANSEL_OFF: begin
                rd_mux[`PP_NPINS-1:0] = st_reg.ansel & impl;
                if (wr) begin
                    st_next.ansel = pwdata[`PP_NPINS-1:0];
                end
            end
            default: begin
                hit = 1'b0;
            end
        endcase
        // Separate register sets for input and output routing
        for (int j = 0; j < `PP_NRI; j++) begin
            if (paddr == `PP_ADDRW'(`PP_INSEL_BASE + 4 * j)) begin
                hit = 1'b1;
                rd_mux[`PP_SELW-1:0] = st_reg.insel[j];
                if (wr) begin
                    st_next.insel[j] = pwdata[`PP_SELW-1:0];
                end
            end
        end
        for (int k = 0; k < `PP_NRP; k++) begin
            if (paddr == `PP_ADDRW'(`PP_OUTSEL_BASE + 4 * k)) begin
                hit = 1'b1;
                rd_mux[`PP_SELW-1:0] = st_reg.outsel[k];
                if (wr) begin
                    st_next.outsel[k] = pwdata[`PP_SELW-1:0];
                end
            end
        end
        // Unmapped writes are dropped
        if (!hit) begin
            st_next = st_reg;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg.dir    <= `PP_DIR_RST;
            st_reg.lat    <= `PP_LAT_RST;
            st_reg.ansel  <= `PP_ANSEL_RST;
            st_reg.insel  <= {`PP_NRI{`PP_INSEL_RST}};
            st_reg.outsel <= {`PP_NRP{`PP_OUTSEL_RST}};
        end else begin
            st_reg <= st_next;
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    property p_oe_owner;
        @(posedge pclk) disable iff (!presetn)
        pad_oe == (fix_act | rp_act | pmp_act | port_drv);
    endproperty
    a_oe_owner: assert property (p_oe_owner) else $error("pad_oe owner mismatch");

    property p_no_loop;
        @(posedge pclk) disable iff (!presetn)
        (fixed_in & port_drv) == '0;
    endproperty
    a_no_loop: assert property (p_no_loop) else $error("port output looped in");

    property p_periph_blocks_port;
        @(posedge pclk) disable iff (!presetn)
        ((fix_act | rp_act | pmp_act) & port_drv) == '0;
    endproperty
    a_periph_blocks_port: assert property (p_periph_blocks_port)
        else $error("port drives under active peripheral");

    property p_dir_drive;
        @(posedge pclk) disable iff (!presetn)
        port_drv == (~st_reg.dir & impl & ~(fix_act | rp_act | pmp_act));
    endproperty
    a_dir_drive: assert property (p_dir_drive) else $error("direction not obeyed");

    property p_reset_inputs;
        @(posedge pclk) disable iff (!presetn)
        $rose(presetn) |-> (st_reg.dir == `PP_DIR_RST) && (port_drv == '0);
    endproperty
    a_reset_inputs: assert property (p_reset_inputs) else $error("pins not inputs");

    property p_port_write_lat;
        @(posedge pclk) disable iff (!presetn)
        (wr && paddr == `PP_PORT_OFF) |=> (st_reg.lat == $past(pwdata[`PP_NPINS-1:0]));
    endproperty
    a_port_write_lat: assert property (p_port_write_lat) else $error("port write lost");

    property p_lat_read;
        @(posedge pclk) disable iff (!presetn)
        (acc && !pwrite && paddr == `PP_LAT_OFF) |-> (prdata == {16'h0000, lat_rd});
    endproperty
    a_lat_read: assert property (p_lat_read) else $error("latch read wrong");

    property p_unimpl_zero;
        @(posedge pclk) disable iff (!presetn)
        (acc && !pwrite && paddr <= `PP_PORT_OFF) |-> ((prdata[`PP_NPINS-1:0] & ~impl) == '0);
    endproperty
    a_unimpl_zero: assert property (p_unimpl_zero) else $error("unimplemented bit read");

    property p_fixed_wins;
        @(posedge pclk) disable iff (!presetn)
        (fix_act[0] && rp_act[0]) |-> (pad_out[0] == fixed_do[0]);
    endproperty
    a_fixed_wins: assert property (p_fixed_wins) else $error("fixed output lost");

    property p_unsel_zero;
        @(posedge pclk) disable iff (!presetn)
        (st_reg.insel[0] >= `PP_SELW'(`PP_NRP)) |-> (rp_in_data[0] == 1'b0);
    endproperty
    a_unsel_zero: assert property (p_unsel_zero) else $error("unselected input live");

    property p_analog_off;
        @(posedge pclk) disable iff (!presetn)
        st_reg.ansel[st_reg.insel[1][2:0]] |-> (rp_in_data[1] == 1'b0);
    endproperty
    a_analog_off: assert property (p_analog_off) else $error("analog pin fed input");

    c_rp_drive: cover property (@(posedge pclk) disable iff (!presetn) rp_act[0] ##1 port_drv[0]);
    c_port_rd: cover property (@(posedge pclk) disable iff (!presetn)
        acc && !pwrite && paddr == `PP_PORT_OFF);
    c_rp_in: cover property (@(posedge pclk) disable iff (!presetn) rp_in_data[2]);
    c_err: cover property (@(posedge pclk) disable iff (!presetn) pslverr);

endmodule

`default_nettype wire

/* File: bench/pad_model.sv */
// External circuitry on the shared pins: drives pins the device releases.
// Assumes the bench chooses which pins it drives and with what level.
`timescale 1ns/1ps
`default_nettype none

`include "pin_port_defines.svh"

module pad_model (
    input  wire logic                 pclk,
    input  wire logic [`PP_NPINS-1:0] pad_out,
    input  wire logic [`PP_NPINS-1:0] pad_oe,
    input  wire logic [`PP_NPINS-1:0] ext_oe,
    input  wire logic [`PP_NPINS-1:0] ext_val,
    output logic      [`PP_NPINS-1:0] pad_in
);
    // ****************************************************************
    // Pin levels
    // ****************************************************************
    logic [`PP_NPINS-1:0] float_reg = 16'h5A5A;

    // Floating pins toggle every cycle so a stale level never reads as valid
    always @(posedge pclk) begin
        float_reg <= ~float_reg;
    end

    // Device drive wins; bench drive on a pin the device owns is ignored
    assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_oe & ext_val)
                  | (~pad_oe & ~ext_oe & float_reg);
endmodule

`default_nettype wire

/* File: bench/shared_pin_port_with_remap_tb.sv */
// Self-checking bench for the shared pin port over APB.
// Assumes APB answers gated by pready, stretched while clk_en is low, and pads modelled by pad_model.
`timescale 1ns/1ps
`default_nettype none

`include "pin_port_defines.svh"

module shared_pin_port_with_remap_tb;
    // ****************************************************************
    // Signals
    // ****************************************************************
    typedef struct packed {logic rd; logic [31:0] d; logic e;} note_s;
    logic                 pclk = 0, presetn = 0, clk_en = 1;
    logic                 psel = 0, penable = 0, pwrite = 0, pready, pslverr;
    logic [11:0]          paddr = 0;
    logic [31:0]          pwdata = 0, prdata;
    logic [15:0]          pad_in, pad_out, pad_oe, fixed_in, ext_oe = 0, ext_val = 0;
    logic [15:0]          fx_en = 0, fx_oe = 0, fx_do = 0, pm_en = 0, pm_oe = 0, pm_do = 0;
    logic [3:0]           ro_oe = 0, ro_do = 0, rp_in;
    logic [15:0]          r;
    note_s                exp_q[$];
    note_s                nt;
    int                   miscompares = 0, n_tests = 0, cyc = 0;

    always #10 pclk = ~pclk;

    pin_port dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .pad_in(pad_in),
        .pad_out(pad_out), .pad_oe(pad_oe), .fixed_en(fx_en), .fixed_oe(fx_oe),
        .fixed_do(fx_do), .fixed_in(fixed_in), .parallel_master_port_en(pm_en),
        .parallel_master_port_oe(pm_oe), .parallel_master_port_do(pm_do),
        .rp_out_oe(ro_oe), .rp_out_data(ro_do), .rp_in_data(rp_in));

    pad_model pads (.pclk(pclk), .pad_out(pad_out), .pad_oe(pad_oe), .ext_oe(ext_oe),
        .ext_val(ext_val), .pad_in(pad_in));

    // ****************************************************************
    // Tasks
    // ****************************************************************
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic print_verdict();
        $display("Comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // Setup, then access held until pready is sampled high at an edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic [31:0] exp, input logic err);
        @(posedge pclk);
        psel    <= 1;
        penable <= 0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        exp_q.push_back('{rd: !w, d: exp, e: err});
        @(posedge pclk);
        penable <= 1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        psel    <= 0;
        penable <= 0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1, a, d, 0, 0);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        apb(0, a, exp, exp, 0);
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge pclk);
        @(negedge pclk);
    endtask

    // Scoreboard: oldest note against each completed transfer
    always @(posedge pclk) begin
        if (psel && penable && pready) begin
            if (exp_q.size() == 0) begin
                chk("unexpected transfer", 1, 0);
            end else begin
                nt = exp_q.pop_front();
                chk("pslverr", pslverr, nt.e);
                if (nt.rd) chk("prdata", prdata, nt.d);
            end
        end
    end

    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            miscompares++;
            print_verdict();
        end
    end

    // ****************************************************************
    // Tests
    // ****************************************************************
    initial begin
        void'($urandom(32'hD181B2BB));
        repeat (10) @(posedge pclk);
        presetn <= 1;
        settle(0);
        chk("pad_oe reset", pad_oe, 0);
        chk("rp_in reset", rp_in, 0);
        rd(`PP_DIR_OFF, 32'h0000_7FFF);
        rd(`PP_LAT_OFF, 0);
        for (int j = 0; j < 4; j++) rd(`PP_INSEL_BASE + 12'(4 * j), 32'h0000_003F);
        rd(`PP_OUTSEL_BASE, 0);
        $display("Test reset done");

        for (int i = 0; i < 4; i++) begin
            r = 16'($urandom);
            wr(`PP_LAT_OFF, {16'h0, r});
            wr(`PP_DIR_OFF, {16'h0, ~r});
            settle(0);
            chk("pad_oe dir", pad_oe, r & `PP_IMPL_MASK);
            chk("pad_out lat", pad_out & pad_oe, r & `PP_IMPL_MASK);
            rd(`PP_LAT_OFF, {16'h0, r & `PP_IMPL_MASK});
        end
        apb(0, 12'h0FC, 0, 0, 1);
        apb(1, 12'h0F8, 32'hFFFF_FFFF, 0, 1);
        rd(`PP_DIR_OFF, {16'h0, ~r & `PP_IMPL_MASK});
        $display("Test latch and direction done");

        wr(`PP_DIR_OFF, 32'h0000_FFFF);
        ext_oe  <= 16'hFFFF;
        ext_val <= 16'($urandom);
        settle(3);
        rd(`PP_PORT_OFF, {16'h0, ext_val & `PP_IMPL_MASK});
        wr(`PP_PORT_OFF, 32'h0000_A5C3);
        rd(`PP_LAT_OFF, 32'h0000_25C3);
        $display("Test pin read done");

        // Frozen clock stretches the access phase until clk_en returns
        clk_en <= 0;
        fork
            wr(`PP_LAT_OFF, 32'h0000_1234);
            begin
                repeat (3) @(posedge pclk);
                chk("stall pready", pready, 0);
                clk_en <= 1;
            end
        join
        rd(`PP_LAT_OFF, 32'h0000_1234);
        $display("Test clock enable done");

        ext_oe <= 16'h0;
        wr(`PP_LAT_OFF, 32'h0000_0001);
        wr(`PP_DIR_OFF, 0);
        wr(`PP_OUTSEL_BASE, 1);
        ro_oe <= 4'h1;
        ro_do <= 4'h1;
        pm_en <= 16'h1;
        pm_oe <= 16'h1;
        settle(1);
        chk("remap over pmp", {pad_oe[0], pad_out[0], pad_oe[15]}, 3'b110);
        fx_en <= 16'h1;
        fx_oe <= 16'h1;
        settle(1);
        chk("fixed over remap", {pad_oe[0], pad_out[0]}, 2'b10);
        fx_oe <= 0;
        settle(1);
        chk("fixed idle", pad_out[0], 1);
        ro_oe <= 0;
        settle(1);
        chk("pmp drives", pad_out[0], 0);
        pm_en <= 0;
        settle(1);
        chk("port bit back", pad_out[0], 1);
        $display("Test priority done");

        wr(`PP_LAT_OFF, 0);
        ro_oe <= 4'hF;
        for (int c = 0; c <= 5; c++) begin
            wr(`PP_OUTSEL_BASE + 12'h008, 32'(c));
            ro_do <= (c >= 1 && c <= 4) ? 4'(1 << (c - 1)) : 4'hF;
            settle(1);
            chk("outsel code", pad_out[2], (c >= 1 && c <= 4) ? 1'b1 : 1'b0);
        end
        $display("Test output codes done");

        fx_en <= 16'h0002;
        wr(`PP_DIR_OFF, 32'h0000_FF0D);
        ext_oe  <= 16'hFF0D;
        ext_val <= 16'hFFFF;
        settle(3);
        chk("no loop through", fixed_in[1], 0);
        chk("port drives own pin", {pad_oe[1], pad_out[1]}, 2'b10);
        wr(`PP_DIR_OFF, 32'h0000_FFFF);
        ext_oe <= 16'hFFFF;
        settle(3);
        chk("fixed input", fixed_in, 16'h0002);
        r = 16'($urandom) | 16'h0030;
        ext_val <= r;
        for (int j = 0; j < 4; j++) wr(`PP_INSEL_BASE + 12'(4 * j), 32'(j + 4));
        wr(`PP_OUTSEL_BASE + 12'h010, 2);
        settle(3);
        chk("remap inputs", rp_in, 4'(r >> 4));
        chk("input owns no buffer", pad_oe[7:5], 0);
        chk("remap out on input pin", pad_oe[4], 1);
        wr(`PP_ANSEL_OFF, 32'h0000_0020);
        settle(1);
        chk("analog kills input", rp_in[1], 0);
        wr(`PP_INSEL_BASE, 9);
        settle(1);
        chk("bad pin select", rp_in[0], 0);
        $display("Test remap inputs done");
        print_verdict();
    end
endmodule

`default_nettype wire
